/* rtl/tdm_i2s_pkg.sv */
// constants, register map and carrier types of the serial audio pin logic
package tdm_i2s_pkg;
	localparam logic [7:0] CTRL_OFF   = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] A_TX_OFF   = 8'h08;
	localparam logic [7:0] A_RX_OFF   = 8'h0C;
	localparam logic [7:0] B_TX_OFF   = 8'h10;
	localparam logic [7:0] B_RX_OFF   = 8'h14;
	localparam logic [7:0] MIC1_OFF   = 8'h18;
	localparam logic [7:0] MIC2_OFF   = 8'h1C;

	localparam int CTRL_A_LSB       = 0;
	localparam int CTRL_B_LSB       = 4;
	localparam int CTRL_MIC_STEREO  = 8;
	localparam int ST_IN_RESET      = 0;
	localparam int ST_RX_NEW        = 1;
	localparam int ST_TX_BUSY       = 3;

	typedef enum logic [1:0] {
		FRAME_I2S = 2'b00,
		FRAME_PCM = 2'b01,
		FRAME_GCI = 2'b10,
		FRAME_RSV = 2'b11
	} frame_mode_t;

	typedef struct packed {
		logic        master;
		frame_mode_t mode;
	} port_cfg_t;

	localparam port_cfg_t PORT_CFG_RESET = '{master: 1'b0, mode: FRAME_I2S};

	typedef struct packed {
		logic [15:0] left;
		logic [15:0] right;
	} audio_frame_t;

	typedef struct packed {
		logic [7:0] right;
		logic [7:0] left;
	} mic_level_t;

	localparam logic [4:0] FIRST_BIT     = 5'h00;
	localparam logic [4:0] LAST_BIT      = 5'h1F;
	localparam logic [4:0] WS_HIGH_FIRST = 5'h0F;
	localparam logic [4:0] WS_HIGH_LAST  = 5'h1E;
	localparam logic [4:0] PCM_PULSE_BIT = 5'h1F;
	localparam logic [4:0] GCI_PULSE_BIT = 5'h00;
	localparam logic [3:0] BCLK_HALF_LAST = 4'h1;
	localparam logic [3:0] MIC_HALF_LAST  = 4'h1;
	localparam logic [5:0] MIC_WIN_LAST   = 6'h3F;
	localparam logic [7:0] LEVEL_MAX      = 8'hFF;
endpackage

/* rtl/tdm_i2s_port_pin_logic.sv */
// serial audio ports, microphone interface and reset gating behind a wishbone slave
//
// Summary of operation
// - while the reset pin is low the block holds reset state and releases every pin it can drive.
// - two independent ports, each set to master or slave and to pcm, gci or i2s framing.
// - each port frames in pcm, gci or i2s timing as configured.
// - one data bit moves per bit clock period on both data lines.
// - pcm master drives the bit clock, pcm slave takes it as input.
// - i2s master drives the bit clock, i2s slave takes it from the far master.
// - pcm master drives a frame pulse, slave aligns to the incoming frame reference.
// - i2s master drives word select, slave takes it as input.
// - after power-up clock and word select are inputs in i2s slave mode.
// - data is received on the data input and sent on the data output, a bit per clock.
// - a clock output feeds the digital microphones.
// - each microphone input takes a stereo or a mono bit stream.
`timescale 1ns/1ns

module serial_audio_port (
	input  wire logic                       mclk_i,
	input  wire logic                       run_i,
	input  wire tdm_i2s_pkg::port_cfg_t     cfg_i,
	input  wire tdm_i2s_pkg::audio_frame_t  tx_word_i,
	input  wire logic                       tx_load_i,
	output logic                            tx_busy_o,
	output tdm_i2s_pkg::audio_frame_t       rx_word_o,
	output logic                            rx_new_o,
	input  wire logic                       bit_clock_i,
	output logic                            bit_clock_o,
	output logic                            bit_clock_oe_n_o,
	input  wire logic                       frame_sync_i,
	output logic                            frame_sync_o,
	output logic                            frame_sync_oe_n_o,
	input  wire logic                       data_in_i,
	output logic                            data_out_o,
	output logic                            data_out_oe_n_o
);
	logic                       drive;
	logic [3:0]                 div_cnt;
	logic                       bclk_gen;
	tdm_i2s_pkg::audio_frame_t  tx_word;
	logic                       tx_req;
	logic                       ack_s1;
	logic                       ack_s2;
	logic                       rx_s1;
	logic                       rx_s2;
	logic                       rx_s3;
	logic                       lr1;
	logic                       lr2;
	tdm_i2s_pkg::port_cfg_t     cs1;
	tdm_i2s_pkg::port_cfg_t     cs2;
	logic                       req_s1;
	logic                       req_s2;
	logic                       tx_ack;
	logic                       fs_prev;
	logic [4:0]                 bit_cnt;
	logic [4:0]                 bit_idx;
	logic [4:0]                 next_bit_cnt;
	logic                       resync;
	logic [31:0]                rx_shift;
	tdm_i2s_pkg::audio_frame_t  rx_hold;
	logic                       rx_tgl;
	tdm_i2s_pkg::audio_frame_t  tx_frame;
	logic                       dout_q;
	logic                       fs_q;
	logic                       fs_level;

	assign drive = run_i & cfg_i.master;
	// master drives clock and framing, slave leaves both pins as inputs
	assign bit_clock_o       = bclk_gen & drive;
	assign bit_clock_oe_n_o  = ~drive;
	assign frame_sync_o      = fs_q & drive;
	assign frame_sync_oe_n_o = ~drive;
	assign data_out_o        = dout_q & run_i;
	assign data_out_oe_n_o   = ~run_i;
	assign tx_busy_o         = tx_req ^ ack_s2;

	// bit clock from the system clock; the pin loops back into bit_clock_i
	always_ff @(posedge mclk_i)
	begin
		if (!drive)
		begin
			div_cnt  <= 4'h0;
			bclk_gen <= 1'b0;
		end
		else if (div_cnt == tdm_i2s_pkg::BCLK_HALF_LAST)
		begin
			div_cnt  <= 4'h0;
			bclk_gen <= ~bclk_gen;
		end
		else
			div_cnt <= div_cnt + 4'h1;
	end

	// transmit word handshake: word held stable until the link acknowledges
	always_ff @(posedge mclk_i)
	begin
		ack_s1 <= tx_ack;
		ack_s2 <= ack_s1;
		if (!run_i)
		begin
			tx_req  <= 1'b0;
			tx_word <= '0;
		end
		else if (tx_load_i && !tx_busy_o)
		begin
			tx_word <= tx_word_i;
			tx_req  <= ~tx_req;
		end
	end

	// receive word: toggle crossing, the held word is stable for a whole frame
	always_ff @(posedge mclk_i)
	begin
		rx_s1 <= rx_tgl;
		rx_s2 <= rx_s1;
		rx_s3 <= rx_s2;
		if (!run_i)
		begin
			rx_word_o <= '0;
			rx_new_o  <= 1'b0;
		end
		else
		begin
			rx_new_o <= rx_s2 ^ rx_s3;
			if (rx_s2 ^ rx_s3)
				rx_word_o <= rx_hold;
		end
	end

	// link reset asserts at once, since a far clock may rest low through reset
	always_ff @(posedge bit_clock_i or negedge run_i)
	begin
		if (!run_i)
		begin
			lr1 <= 1'b1;
			lr2 <= 1'b1;
		end
		else
		begin
			lr1 <= 1'b0;
			lr2 <= lr1;
		end
	end

	// link domain synchronisers; a mode change settles within two bit clocks
	always_ff @(posedge bit_clock_i)
	begin
		cs1    <= cfg_i;
		cs2    <= cs1;
		req_s1 <= tx_req;
		req_s2 <= req_s1;
	end

	// slave alignment to the far frame reference
	always_comb
	begin
		bit_idx = bit_cnt;
		resync  = 1'b0;
		if (!cs2.master)
		begin
			case (cs2.mode)
				tdm_i2s_pkg::FRAME_GCI:
					if (frame_sync_i && !fs_prev)
						bit_idx = tdm_i2s_pkg::FIRST_BIT;
				tdm_i2s_pkg::FRAME_PCM:
					resync = frame_sync_i;
				default:
					resync = fs_prev && !frame_sync_i;
			endcase
		end
		next_bit_cnt = resync ? tdm_i2s_pkg::FIRST_BIT : bit_idx + 5'h01;
	end

	// receive on the rising edge, one bit per bit clock
	always_ff @(posedge bit_clock_i or posedge lr2)
	begin
		if (lr2)
		begin
			fs_prev  <= 1'b0;
			bit_cnt  <= tdm_i2s_pkg::LAST_BIT;
			rx_shift <= '0;
			rx_hold  <= '0;
			rx_tgl   <= 1'b0;
			tx_frame <= '0;
			tx_ack   <= 1'b0;
		end
		else
		begin
			fs_prev  <= frame_sync_i;
			bit_cnt  <= next_bit_cnt;
			rx_shift <= {rx_shift[30:0], data_in_i};
			if (bit_idx == tdm_i2s_pkg::LAST_BIT)
			begin
				rx_hold <= {rx_shift[30:0], data_in_i};
				rx_tgl  <= ~rx_tgl;
				// without a fresh word the last frame repeats
				if (req_s2 != tx_ack)
				begin
					tx_frame <= tx_word;
					tx_ack   <= req_s2;
				end
			end
		end
	end

	always_comb
	begin
		case (cs2.mode)
			tdm_i2s_pkg::FRAME_PCM:
				fs_level = (bit_cnt == tdm_i2s_pkg::PCM_PULSE_BIT);
			tdm_i2s_pkg::FRAME_GCI:
				fs_level = (bit_cnt == tdm_i2s_pkg::GCI_PULSE_BIT);
			default:
				fs_level = (bit_cnt >= tdm_i2s_pkg::WS_HIGH_FIRST) &&
					(bit_cnt <= tdm_i2s_pkg::WS_HIGH_LAST);
		endcase
	end

	// transmit and framing change on the falling edge, msb of left word first
	always_ff @(negedge bit_clock_i or posedge lr2)
	begin
		if (lr2)
		begin
			dout_q <= 1'b0;
			fs_q   <= 1'b0;
		end
		else
		begin
			dout_q <= tx_frame[tdm_i2s_pkg::LAST_BIT - bit_cnt];
			fs_q   <= fs_level;
		end
	end
endmodule // serial_audio_port

module tdm_i2s_port_pin_logic (
	input  wire logic         mclk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         rst_pin_n_i,
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	input  wire logic         wb_we_i,
	input  wire logic [7:0]   wb_adr_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic [31:0]  wb_dat_i,
	output logic [31:0]       wb_dat_o,
	output logic              wb_ack_o,
	input  wire logic         port_a_bit_clock_i,
	output logic              port_a_bit_clock_o,
	output logic              port_a_bit_clock_oe_n_o,
	input  wire logic         port_a_frame_sync_i,
	output logic              port_a_frame_sync_o,
	output logic              port_a_frame_sync_oe_n_o,
	input  wire logic         port_a_data_in_i,
	output logic              port_a_data_out_o,
	output logic              port_a_data_out_oe_n_o,
	input  wire logic         port_b_bit_clock_i,
	output logic              port_b_bit_clock_o,
	output logic              port_b_bit_clock_oe_n_o,
	input  wire logic         port_b_frame_sync_i,
	output logic              port_b_frame_sync_o,
	output logic              port_b_frame_sync_oe_n_o,
	input  wire logic         port_b_data_in_i,
	output logic              port_b_data_out_o,
	output logic              port_b_data_out_oe_n_o,
	output logic              mic_clock_out_o,
	output logic              mic_clock_out_oe_n_o,
	input  wire logic         mic_data_in_one_i,
	input  wire logic         mic_data_in_two_i
);
	logic                       rp_s1;
	logic                       rp_s2;
	logic                       dev_rst;
	logic                       run;
	tdm_i2s_pkg::port_cfg_t     cfg [2];
	logic [1:0]                 mic_stereo;
	logic [1:0]                 rx_flag;
	logic [1:0]                 rx_new;
	logic [1:0]                 tx_busy;
	tdm_i2s_pkg::audio_frame_t  rx_word [2];
	logic [1:0]                 tx_load;
	logic [1:0]                 rx_clr;
	logic                       wb_req;
	logic                       wr_take;
	logic                       rd_take;
	logic [31:0]                rd_mux;
	logic [31:0]                ctrl_val;
	logic [31:0]                next_ctrl;
	logic [3:0]                 mic_div;
	logic                       mic_clk;
	logic [5:0]                 mic_win;
	logic [1:0]                 md_s1;
	logic [1:0]                 md_s2;
	tdm_i2s_pkg::mic_level_t    acc [2];
	tdm_i2s_pkg::mic_level_t    level [2];
	logic                       mic_tick;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		return r;
	endfunction

	function automatic logic [7:0] count_one(input logic [7:0] v, input logic b);
		return (b && v != tdm_i2s_pkg::LEVEL_MAX) ? v + 8'h01 : v;
	endfunction

	// reset pin is asynchronous to mclk, so it passes two flops first
	always_ff @(posedge mclk_i)
	begin
		rp_s1 <= rst_pin_n_i;
		rp_s2 <= rp_s1;
	end

	assign dev_rst = sys_rst_i | ~rp_s2;

	always_ff @(posedge mclk_i)
		run <= ~dev_rst;

	// wishbone classic: ack one cycle after the request, writes land with ack
	assign wb_req  = wb_cyc_i & wb_stb_i;
	assign wr_take = wb_req & wb_we_i & wb_ack_o & run;
	assign rd_take = wb_req & ~wb_we_i & ~wb_ack_o;

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req & ~wb_ack_o;
	end

	always_comb
	begin
		ctrl_val = '0;
		ctrl_val[tdm_i2s_pkg::CTRL_A_LSB +: 3] = cfg[0];
		ctrl_val[tdm_i2s_pkg::CTRL_B_LSB +: 3] = cfg[1];
		ctrl_val[tdm_i2s_pkg::CTRL_MIC_STEREO +: 2] = mic_stereo;
		next_ctrl = merge_bytes(ctrl_val, wb_dat_i, wb_sel_i);
	end

	// role and framing: reset and reset pin both return to i2s slave
	always_ff @(posedge mclk_i)
	begin
		if (dev_rst)
		begin
			cfg[0]     <= tdm_i2s_pkg::PORT_CFG_RESET;
			cfg[1]     <= tdm_i2s_pkg::PORT_CFG_RESET;
			mic_stereo <= 2'b00;
		end
		else if (wr_take && wb_adr_i == tdm_i2s_pkg::CTRL_OFF)
		begin
			cfg[0]     <= next_ctrl[tdm_i2s_pkg::CTRL_A_LSB +: 3];
			cfg[1]     <= next_ctrl[tdm_i2s_pkg::CTRL_B_LSB +: 3];
			mic_stereo <= next_ctrl[tdm_i2s_pkg::CTRL_MIC_STEREO +: 2];
		end
	end

	assign tx_load[0] = wr_take && wb_adr_i == tdm_i2s_pkg::A_TX_OFF;
	assign tx_load[1] = wr_take && wb_adr_i == tdm_i2s_pkg::B_TX_OFF;
	assign rx_clr[0]  = rd_take && wb_adr_i == tdm_i2s_pkg::A_RX_OFF;
	assign rx_clr[1]  = rd_take && wb_adr_i == tdm_i2s_pkg::B_RX_OFF;

	// new-word flags: an arriving word beats the clearing read
	always_ff @(posedge mclk_i)
	begin
		if (dev_rst)
			rx_flag <= 2'b00;
		else
			rx_flag <= rx_new | (rx_flag & ~rx_clr);
	end

	always_comb
	begin
		rd_mux = '0;
		case (wb_adr_i)
			tdm_i2s_pkg::CTRL_OFF:
				rd_mux = ctrl_val;
			tdm_i2s_pkg::STATUS_OFF:
			begin
				rd_mux[tdm_i2s_pkg::ST_IN_RESET] = ~run;
				rd_mux[tdm_i2s_pkg::ST_RX_NEW +: 2] = rx_flag;
				rd_mux[tdm_i2s_pkg::ST_TX_BUSY +: 2] = tx_busy;
			end
			tdm_i2s_pkg::A_RX_OFF:
				rd_mux = rx_word[0];
			tdm_i2s_pkg::B_RX_OFF:
				rd_mux = rx_word[1];
			tdm_i2s_pkg::MIC1_OFF:
				rd_mux[15:0] = level[0];
			tdm_i2s_pkg::MIC2_OFF:
				rd_mux[15:0] = level[1];
			default:
				rd_mux = '0;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			wb_dat_o <= '0;
		else if (rd_take)
			wb_dat_o <= rd_mux;
	end

	serial_audio_port u_port_a (
		.mclk_i            (mclk_i),
		.run_i             (run),
		.cfg_i             (cfg[0]),
		.tx_word_i         (wb_dat_i),
		.tx_load_i         (tx_load[0]),
		.tx_busy_o         (tx_busy[0]),
		.rx_word_o         (rx_word[0]),
		.rx_new_o          (rx_new[0]),
		.bit_clock_i       (port_a_bit_clock_i),
		.bit_clock_o       (port_a_bit_clock_o),
		.bit_clock_oe_n_o  (port_a_bit_clock_oe_n_o),
		.frame_sync_i      (port_a_frame_sync_i),
		.frame_sync_o      (port_a_frame_sync_o),
		.frame_sync_oe_n_o (port_a_frame_sync_oe_n_o),
		.data_in_i         (port_a_data_in_i),
		.data_out_o        (port_a_data_out_o),
		.data_out_oe_n_o   (port_a_data_out_oe_n_o)
	);

	serial_audio_port u_port_b (
		.mclk_i            (mclk_i),
		.run_i             (run),
		.cfg_i             (cfg[1]),
		.tx_word_i         (wb_dat_i),
		.tx_load_i         (tx_load[1]),
		.tx_busy_o         (tx_busy[1]),
		.rx_word_o         (rx_word[1]),
		.rx_new_o          (rx_new[1]),
		.bit_clock_i       (port_b_bit_clock_i),
		.bit_clock_o       (port_b_bit_clock_o),
		.bit_clock_oe_n_o  (port_b_bit_clock_oe_n_o),
		.frame_sync_i      (port_b_frame_sync_i),
		.frame_sync_o      (port_b_frame_sync_o),
		.frame_sync_oe_n_o (port_b_frame_sync_oe_n_o),
		.data_in_i         (port_b_data_in_i),
		.data_out_o        (port_b_data_out_o),
		.data_out_oe_n_o   (port_b_data_out_oe_n_o)
	);

	// microphone clock and a coarse density count per channel
	assign mic_clock_out_o      = mic_clk & run;
	assign mic_clock_out_oe_n_o = ~run;
	assign mic_tick = (mic_div == tdm_i2s_pkg::MIC_HALF_LAST);

	always_ff @(posedge mclk_i)
	begin
		md_s1 <= {mic_data_in_two_i, mic_data_in_one_i};
		md_s2 <= md_s1;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!run)
		begin
			mic_div <= 4'h0;
			mic_clk <= 1'b0;
		end
		else if (mic_tick)
		begin
			mic_div <= 4'h0;
			mic_clk <= ~mic_clk;
		end
		else
			mic_div <= mic_div + 4'h1;
	end

	// left rides the rising half, right the falling half; mono uses rising only
	always_ff @(posedge mclk_i)
	begin
		if (!run)
		begin
			mic_win <= 6'h00;
			for (int i = 0; i < 2; i++)
			begin
				acc[i]   <= '0;
				level[i] <= '0;
			end
		end
		else if (mic_tick)
		begin
			if (mic_clk)
				mic_win <= mic_win + 6'h01;
			for (int i = 0; i < 2; i++)
			begin
				// the closing falling half still carries a right sample
				if (mic_clk && mic_win == tdm_i2s_pkg::MIC_WIN_LAST)
				begin
					level[i].left  <= acc[i].left;
					level[i].right <= mic_stereo[i] ? count_one(acc[i].right, md_s2[i]) : '0;
					acc[i]         <= '0;
				end
				else if (!mic_clk)
					acc[i].left <= count_one(acc[i].left, md_s2[i]);
				else if (mic_stereo[i])
					acc[i].right <= count_one(acc[i].right, md_s2[i]);
			end
		end
	end
endmodule // tdm_i2s_port_pin_logic

/* verification/tdm_i2s_port_pin_logic_properties.sv */
// pin and bus assertions for the serial audio pin logic
`timescale 1ns/1ns

module tdm_i2s_port_pin_logic_properties (
	input logic mclk_i,
	input logic sys_rst_i,
	input logic rst_pin_n_i,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_ack_o,
	input logic port_a_bit_clock_o,
	input logic port_a_bit_clock_oe_n_o,
	input logic port_a_frame_sync_o,
	input logic port_a_frame_sync_oe_n_o,
	input logic port_a_data_out_oe_n_o,
	input logic port_b_bit_clock_oe_n_o,
	input logic port_b_frame_sync_oe_n_o,
	input logic port_b_data_out_oe_n_o,
	input logic mic_clock_out_o,
	input logic mic_clock_out_oe_n_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);

	logic all_hiz;
	assign all_hiz = port_a_bit_clock_oe_n_o && port_a_frame_sync_oe_n_o
		&& port_a_data_out_oe_n_o && port_b_bit_clock_oe_n_o
		&& port_b_frame_sync_oe_n_o && port_b_data_out_oe_n_o && mic_clock_out_oe_n_o;

	// a level may end early only when the pin is let go
	sequence bclk_half_s;
		($stable(port_a_bit_clock_o) || port_a_bit_clock_oe_n_o)
			##1 ($changed(port_a_bit_clock_o) || port_a_bit_clock_oe_n_o);
	endsequence
	sequence mic_half_s;
		($stable(mic_clock_out_o) || mic_clock_out_oe_n_o)
			##1 ($changed(mic_clock_out_o) || mic_clock_out_oe_n_o);
	endsequence

	pin_reset_hiz_a: assert property (!rst_pin_n_i [*5] |-> all_hiz)
		else $error("outputs driven while reset pin low");
	sys_reset_a: assert property ($fell(sys_rst_i) |-> all_hiz && !wb_ack_o)
		else $error("outputs active right after reset");
	power_up_slave_a: assert property ($fell(sys_rst_i) |->
		(port_a_bit_clock_oe_n_o && port_a_frame_sync_oe_n_o && port_b_bit_clock_oe_n_o) [*3])
		else $error("clock or select driven after power up");
	data_drive_a: assert property (rst_pin_n_i [*8] |->
		!port_a_data_out_oe_n_o && !port_b_data_out_oe_n_o && !mic_clock_out_oe_n_o)
		else $error("data or mic clock not driven out of reset");
	ack_reply_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus access not answered next cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	role_pair_a: assert property (1'b1 |->
		port_a_bit_clock_oe_n_o == port_a_frame_sync_oe_n_o
		&& port_b_bit_clock_oe_n_o == port_b_frame_sync_oe_n_o)
		else $error("clock and sync drive roles differ");
	slave_quiet_a: assert property (port_a_frame_sync_oe_n_o |->
		!port_a_frame_sync_o && !port_a_bit_clock_o)
		else $error("slave port shows driven clock or sync");
	bit_clock_rate_a: assert property (!port_a_bit_clock_oe_n_o
		&& $changed(port_a_bit_clock_o) |=> bclk_half_s)
		else $error("master bit clock half period not two cycles");
	mic_clock_a: assert property (!mic_clock_out_oe_n_o
		&& $changed(mic_clock_out_o) |=> mic_half_s)
		else $error("mic clock half period not two cycles");
endmodule // tdm_i2s_port_pin_logic_properties

bind tdm_i2s_port_pin_logic tdm_i2s_port_pin_logic_properties tdm_i2s_port_pin_logic_properties_i (
	.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .rst_pin_n_i(rst_pin_n_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.port_a_bit_clock_o(port_a_bit_clock_o), .port_a_bit_clock_oe_n_o(port_a_bit_clock_oe_n_o),
	.port_a_frame_sync_o(port_a_frame_sync_o),
	.port_a_frame_sync_oe_n_o(port_a_frame_sync_oe_n_o),
	.port_a_data_out_oe_n_o(port_a_data_out_oe_n_o),
	.port_b_bit_clock_oe_n_o(port_b_bit_clock_oe_n_o),
	.port_b_frame_sync_oe_n_o(port_b_frame_sync_oe_n_o),
	.port_b_data_out_oe_n_o(port_b_data_out_oe_n_o),
	.mic_clock_out_o(mic_clock_out_o), .mic_clock_out_oe_n_o(mic_clock_out_oe_n_o));

/* verification/codec_partner.sv */
// behavioural codec that masters the serial link toward a slave port
`timescale 1ns/1ns

module codec_partner (
	input  wire logic                      run_i,
	input  wire tdm_i2s_pkg::frame_mode_t  mode_i,
	input  wire tdm_i2s_pkg::audio_frame_t word_i,
	input  wire logic                      data_i,
	output logic                           bclk_o,
	output logic                           fs_o,
	output logic                           data_o,
	output tdm_i2s_pkg::audio_frame_t      got_o
);
	logic [31:0] shift;

	initial
	begin
		bclk_o = 1'b0;
		fs_o = 1'b0;
		data_o = 1'b0;
		got_o = '0;
		shift = '0;
	end

	// clock runs only inside whole frames and rests low, so no stray edge reaches the port
	always
	begin
		wait (run_i === 1'b1);
		for (int i = 0; i < 32; i++)
		begin
			#40;
			data_o = word_i[31 - i];
			case (mode_i)
				tdm_i2s_pkg::FRAME_PCM: fs_o = (i == 31);
				tdm_i2s_pkg::FRAME_GCI: fs_o = (i == 0);
				default: fs_o = (i >= 15) && (i <= 30);
			endcase
			#40 bclk_o = 1'b1;
			shift[31 - i] = data_i;
			#80 bclk_o = 1'b0;
		end
		got_o = shift;
		if (run_i !== 1'b1)
			data_o = ~data_o;
	end
endmodule // codec_partner

/* verification/testbench.sv */
// self-checking bench for the serial audio pin logic
`timescale 1ns/1ns

module testbench;
	logic        mclk_i, sys_rst_i, rst_pin_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rdat;
	logic        a_clk_o, a_clk_oe_n, a_fs_o, a_fs_oe_n, a_dat_o, a_dat_oe_n;
	logic        b_clk_o, b_clk_oe_n, b_fs_o, b_fs_oe_n, b_dat_o, b_dat_oe_n;
	logic        mic_clk, mic_oe_n, mic_one, mic_two, run, p_clk, p_fs, p_dat;
	tdm_i2s_pkg::frame_mode_t  p_mode;
	tdm_i2s_pkg::audio_frame_t p_word, p_got;
	int          miscompares, check_count, hi, lo;
	logic [31:0] words [3] = '{32'h9B1E_62D4, 32'h0F3C_C3F1, 32'h8001_7FFE};
	logic [31:0] hi_exp [3] = '{32'h40, 32'h4, 32'h4};
	wire         a_clk = a_clk_oe_n ? p_clk : a_clk_o;
	wire         a_fs = a_fs_oe_n ? p_fs : a_fs_o;
	wire         b_clk = b_clk_oe_n ? p_clk : b_clk_o;
	wire         b_fs = b_fs_oe_n ? p_fs : b_fs_o;
	wire         fs_both = a_fs_o & b_fs_o;
	wire [6:0]   oes = {a_clk_oe_n, a_fs_oe_n, a_dat_oe_n, b_clk_oe_n, b_fs_oe_n, b_dat_oe_n,
		mic_oe_n};

	tdm_i2s_port_pin_logic tdm_i2s_port_pin_logic_i (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .rst_pin_n_i(rst_pin_n_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.port_a_bit_clock_i(a_clk), .port_a_bit_clock_o(a_clk_o),
		.port_a_bit_clock_oe_n_o(a_clk_oe_n), .port_a_frame_sync_i(a_fs),
		.port_a_frame_sync_o(a_fs_o), .port_a_frame_sync_oe_n_o(a_fs_oe_n),
		.port_a_data_in_i(p_dat), .port_a_data_out_o(a_dat_o), .port_a_data_out_oe_n_o(a_dat_oe_n),
		.port_b_bit_clock_i(b_clk), .port_b_bit_clock_o(b_clk_o),
		.port_b_bit_clock_oe_n_o(b_clk_oe_n), .port_b_frame_sync_i(b_fs),
		.port_b_frame_sync_o(b_fs_o), .port_b_frame_sync_oe_n_o(b_fs_oe_n),
		.port_b_data_in_i(p_dat), .port_b_data_out_o(b_dat_o), .port_b_data_out_oe_n_o(b_dat_oe_n),
		.mic_clock_out_o(mic_clk), .mic_clock_out_oe_n_o(mic_oe_n),
		.mic_data_in_one_i(mic_one), .mic_data_in_two_i(mic_two));

	codec_partner codec_partner_i (.run_i(run), .mode_i(p_mode), .word_i(p_word),
		.data_i(a_dat_o ^ b_dat_o), .bclk_o(p_clk), .fs_o(p_fs), .data_o(p_dat), .got_o(p_got));

	always #50 mclk_i = ~mclk_i;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		@(posedge mclk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge mclk_i);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (n >= 20)
			chk("bus ack", 32'h1, 32'h0);
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
		wb_xfer(1'b1, adr, wd);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] mask,
		input logic [31:0] exp);
		wb_xfer(1'b0, adr, 32'h0);
		chk(what, exp, rdat & mask);
	endtask

	task automatic measure;
		int n;
		for (n = 0; n < 200 && fs_both !== 1'b0; n++) @(posedge mclk_i);
		for (n = 0; n < 200 && fs_both !== 1'b1; n++) @(posedge mclk_i);
		for (hi = 0; hi < 200 && fs_both === 1'b1; hi++) @(posedge mclk_i);
		for (lo = 0; lo < 200 && fs_both === 1'b0; lo++) @(posedge mclk_i);
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		mclk_i = 1'b0;
		sys_rst_i = 1'b1;
		rst_pin_n_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'hF;
		{mic_one, mic_two, run} = 3'h0;
		p_mode = tdm_i2s_pkg::FRAME_I2S;
		p_word = '0;
		repeat (10) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		chk("pin roles", 32'h6C, {25'h0, oes});
		rd_chk("ctrl", tdm_i2s_pkg::CTRL_OFF, 32'hFFFF_FFFF, 32'h0);
		rd_chk("status", tdm_i2s_pkg::STATUS_OFF, 32'h1F, 32'h0);
		rd_chk("tx readback", tdm_i2s_pkg::A_TX_OFF, 32'hFFFF_FFFF, 32'h0);
		rd_chk("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0);
		$display("test reset_state done");
		for (int m = 0; m < 3; m++)
		begin
			wr(tdm_i2s_pkg::CTRL_OFF, {26'h0, 2'(m), 2'h0, 2'(m)});
			wr(tdm_i2s_pkg::A_TX_OFF, ~words[m]);
			wr(tdm_i2s_pkg::B_TX_OFF, words[(m + 1) % 3]);
			p_word <= words[m];
			p_mode <= tdm_i2s_pkg::frame_mode_t'(2'(m));
			run <= 1'b1;
			repeat (300) @(posedge mclk_i);
			run <= 1'b0;
			repeat (70) @(posedge mclk_i);
			rd_chk("rx flags", tdm_i2s_pkg::STATUS_OFF, 32'h1F, 32'h06);
			rd_chk("a rx", tdm_i2s_pkg::A_RX_OFF, 32'hFFFF_FFFF, words[m]);
			rd_chk("b rx", tdm_i2s_pkg::B_RX_OFF, 32'hFFFF_FFFF, words[m]);
			rd_chk("flags clear", tdm_i2s_pkg::STATUS_OFF, 32'h1F, 32'h0);
			chk("codec got", ~words[m] ^ words[(m + 1) % 3], p_got);
			$display("test slave mode %0d done", m);
		end
		for (int m = 0; m < 3; m++)
		begin
			wr(tdm_i2s_pkg::CTRL_OFF, {25'h0, 1'b1, 2'(m), 1'b0, 1'b1, 2'(m)});
			repeat (300) @(posedge mclk_i);
			chk("master roles", 32'h00, {25'h0, oes});
			measure();
			chk("sync high", hi_exp[m], 32'(hi));
			chk("sync period", 32'h80, 32'(hi + lo));
			$display("test master mode %0d done", m);
		end
		rst_pin_n_i <= 1'b0;
		repeat (10) @(posedge mclk_i);
		chk("pin reset roles", 32'h7F, {25'h0, oes});
		rst_pin_n_i <= 1'b1;
		repeat (8) @(posedge mclk_i);
		rd_chk("ctrl after pin", tdm_i2s_pkg::CTRL_OFF, 32'hFFFF_FFFF, 32'h0);
		chk("slave after pin", 32'h6C, {25'h0, oes});
		$display("test pin_reset done");
		mic_one <= 1'b1;
		wr(tdm_i2s_pkg::CTRL_OFF, 32'h0000_0100);
		repeat (700) @(posedge mclk_i);
		rd_chk("mic stereo", tdm_i2s_pkg::MIC1_OFF, 32'hFFFF, 32'h4040);
		rd_chk("mic quiet", tdm_i2s_pkg::MIC2_OFF, 32'hFFFF, 32'h0);
		wr(tdm_i2s_pkg::CTRL_OFF, 32'h0);
		repeat (700) @(posedge mclk_i);
		rd_chk("mic mono", tdm_i2s_pkg::MIC1_OFF, 32'hFFFF, 32'h0040);
		$display("test mic done");
		close_out();
	end

	initial
	begin
		#3000000;
		miscompares++;
		$display("CHECK FAILED watchdog expected finish seen timeout");
		close_out();
	end
endmodule // testbench
